// ### hw/rosb_pkg.sv
package rosb_pkg;

  // register bus geometry
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned SEL_W = 5;
  localparam int unsigned FUNC_COUNT = 32;
  localparam int unsigned PIN_COUNT = 6;
  localparam int unsigned PIN_FIRST = 12;

  // register offsets (word addresses on the plain port)
  localparam logic [3:0] OFS_PIN12_13 = 4'h0;
  localparam logic [3:0] OFS_PIN14_15 = 4'h1;
  localparam logic [3:0] OFS_PIN16_17 = 4'h2;

  // field positions inside each selector register
  localparam int unsigned HI_FIELD_LSB = 8;
  localparam int unsigned LO_FIELD_LSB = 0;

  // implemented-bit mask: bits 12-8 and 4-0
  localparam logic [15:0] SEL_MASK = 16'h1F1F;

  // value after reset
  localparam logic [4:0] SEL_RESET = 5'h00;
  localparam logic [15:0] RD_RESET = 16'h0000;

  // bus request bundle
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } rosb_req_t;

  // one selector code per remappable pin, pin 12 at index 0
  typedef logic [5:0][4:0] rosb_sel_vec_t;

endpackage

// ### hw/rosb_sel_mux.sv
`timescale 1ns/100ps
`default_nettype none
// registered selection of one peripheral output per remappable pin
module rosb_sel_mux
  import rosb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // selector codes and peripheral outputs
  input wire rosb_sel_vec_t sel,
  input wire logic [FUNC_COUNT-1:0] func_out,
  // driven pin levels
  output logic [PIN_COUNT-1:0] pin_out
);

  // one flop per pin so the pin driver sees a glitch-free level
  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : g_pin
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          pin_out[g] <= 1'b0;
        end else begin
          pin_out[g] <= func_out[sel[g]];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ### hw/rosb_remap_output_select_bank.sv
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// RULE1: register one: bits 12-8 pick pin 13 output, bits 4-0 pick pin 12.
// RULE2: register two: bits 12-8 pick pin 15 output, bits 4-0 pick pin 14.
// RULE3: register three: bits 12-8 pick pin 17 output, bits 4-0 pick pin 16.
// RULE4: bits 15-13 and 7-5 of every register are absent and read zero.
// RULE5: register three exists only on the 44-pin package variant.
// RULE6: selector bits read/write, clear at reset; absent bits ignore writes.
module rosb_remap_output_select_bank
  import rosb_pkg::*;
#(
  parameter bit LARGE_PACKAGE = 1'b1
)
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // register port
  input wire logic [rosb_pkg::ADDR_W-1:0] ADDR,
  input wire logic [rosb_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [rosb_pkg::DATA_W-1:0] RDATA,
  // peripheral outputs and pins
  input wire logic [rosb_pkg::FUNC_COUNT-1:0] FUNC_OUT,
  output logic [rosb_pkg::PIN_COUNT-1:0] PIN_OUT
);

  import rosb_pkg::*;

  rosb_req_t req;
  logic [4:0] remap_pin12_function_q;
  logic [4:0] remap_pin13_function_q;
  logic [4:0] remap_pin14_function_q;
  logic [4:0] remap_pin15_function_q;
  logic [4:0] remap_pin16_function_q;
  logic [4:0] remap_pin17_function_q;
  logic [15:0] rdata_d;
  logic [15:0] rdata_q;
  rosb_sel_vec_t sel;

  // pack a field pair into a register image, absent bits zero
  function automatic logic [15:0] pack_pair(input logic [4:0] hi,
                                            input logic [4:0] lo);
    logic [15:0] v;
    v = 16'h0000;
    v[HI_FIELD_LSB +: SEL_W] = hi;
    v[LO_FIELD_LSB +: SEL_W] = lo;
    return v & SEL_MASK; // see RULE4
  endfunction

  // write strobe decode for one register
  function automatic logic hit(input rosb_req_t r, input logic [3:0] ofs);
    return r.wr && (r.addr == ofs);
  endfunction

  // bundle the bus signals
  assign req.addr = ADDR;
  assign req.wdata = WDATA;
  assign req.wr = WR;
  assign req.rd = RD;

  // pins 12 and 13 selectors
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      remap_pin12_function_q <= SEL_RESET; // see RULE6
      remap_pin13_function_q <= SEL_RESET;
    end else if (hit(req, OFS_PIN12_13)) begin
      remap_pin13_function_q <= req.wdata[HI_FIELD_LSB +: SEL_W]; // see RULE1
      remap_pin12_function_q <= req.wdata[LO_FIELD_LSB +: SEL_W]; // see RULE1
    end
  end

  // pins 14 and 15 selectors
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      remap_pin14_function_q <= SEL_RESET; // see RULE6
      remap_pin15_function_q <= SEL_RESET;
    end else if (hit(req, OFS_PIN14_15)) begin
      remap_pin15_function_q <= req.wdata[HI_FIELD_LSB +: SEL_W]; // see RULE2
      remap_pin14_function_q <= req.wdata[LO_FIELD_LSB +: SEL_W]; // see RULE2
    end
  end

  // pins 16 and 17 selectors, held at reset on the small package
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || !LARGE_PACKAGE) begin
      remap_pin16_function_q <= SEL_RESET; // see RULE5
      remap_pin17_function_q <= SEL_RESET;
    end else if (hit(req, OFS_PIN16_17)) begin
      remap_pin17_function_q <= req.wdata[HI_FIELD_LSB +: SEL_W]; // see RULE3
      remap_pin16_function_q <= req.wdata[LO_FIELD_LSB +: SEL_W]; // see RULE3
    end
  end

  // read mux; unmapped or absent registers read zero
  always_comb begin
    rdata_d = RD_RESET;
    if (req.rd) begin
      case (req.addr)
        OFS_PIN12_13: begin
          rdata_d = pack_pair(remap_pin13_function_q, remap_pin12_function_q);
        end
        OFS_PIN14_15: begin
          rdata_d = pack_pair(remap_pin15_function_q, remap_pin14_function_q);
        end
        OFS_PIN16_17: begin
          if (LARGE_PACKAGE) begin // see RULE5
            rdata_d = pack_pair(remap_pin17_function_q,
                                remap_pin16_function_q);
          end
        end
        default: begin
          rdata_d = RD_RESET;
        end
      endcase
    end
  end

  // read data register, valid the cycle after the strobe only
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      rdata_q <= RD_RESET;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign RDATA = rdata_q;

  // selector vector, pin 12 first
  assign sel[0] = remap_pin12_function_q;
  assign sel[1] = remap_pin13_function_q;
  assign sel[2] = remap_pin14_function_q;
  assign sel[3] = remap_pin15_function_q;
  assign sel[4] = remap_pin16_function_q;
  assign sel[5] = remap_pin17_function_q;

  // peripheral output routing to pins
  rosb_sel_mux rosb_sel_mux_inst (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .sel(sel),
    .func_out(FUNC_OUT),
    .pin_out(PIN_OUT)
  );

endmodule
`default_nettype wire

// ### testbench/rosb_props.sv
`timescale 1ns/100ps
`default_nettype none
module rosb_props
  import rosb_pkg::*;
#(parameter bit LARGE_PACKAGE = 1'b1)
(
  // watched ports
  input wire logic CORE_CLK, RST_N, WR, RD,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA, RDATA,
  input wire logic [31:0] FUNC_OUT,
  input wire logic [5:0] PIN_OUT
);
  logic [31:0] f_q;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  // peripheral outputs one cycle back
  always_ff @(posedge CORE_CLK) f_q <= FUNC_OUT;
  // a written field steers its pin two cycles on
  property p_pin(a, i, h);
    WR && ADDR == a && (a < 2 || LARGE_PACKAGE) ##1 !WR |=>
      PIN_OUT[i] == f_q[$past(h ? WDATA[12:8] : WDATA[4:0], 2)];
  endproperty
  a_pin13_steer:
    assert property (p_pin(0, 1, 1)) else $error("pin 13 wrong");
  a_pin14_steer:
    assert property (p_pin(1, 2, 0)) else $error("pin 14 wrong");
  a_pin17_steer:
    assert property (p_pin(2, 5, 1)) else $error("pin 17 wrong");
  a_absent_bits:
    assert property (RD |=> !RDATA[15:13] && !RDATA[7:5])
    else $error("absent bits set");
  a_absent_reg:
    assert property (RD && (ADDR > 2 || ADDR == 2 && !LARGE_PACKAGE)
      |=> RDATA == 16'h0000) else $error("absent register read");
  a_write_read:
    assert property (WR && ADDR < (LARGE_PACKAGE ? 3 : 2) ##1
      RD && ADDR == $past(ADDR) |=> RDATA == ($past(WDATA, 2) & SEL_MASK))
    else $error("readback wrong");
  // main scenarios
  c_reg_three: cover property (WR && ADDR == 2);
  c_readback: cover property (RD ##1 RDATA != 16'h0000);
  c_back2back: cover property (WR ##1 RD);
endmodule
bind rosb_remap_output_select_bank rosb_props #(.LARGE_PACKAGE(LARGE_PACKAGE))
  rosb_props_inst (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .WR(WR), .RD(RD),
  .ADDR(ADDR), .WDATA(WDATA), .RDATA(RDATA), .FUNC_OUT(FUNC_OUT),
  .PIN_OUT(PIN_OUT));
`default_nettype wire

// ### testbench/rosb_remap_output_select_bank_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module rosb_remap_output_select_bank_tb_top;
  import rosb_pkg::*;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata;
  logic [31:0] func = 32'h8000_000A;
  logic [5:0] pins;
  int fail_count = 0, checks_done = 0;
  // 40 MHz core clock
  always #12.5 clk = ~clk;
  rosb_remap_output_select_bank rosb_remap_output_select_bank_inst (
    .CORE_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .FUNC_OUT(func), .PIN_OUT(pins));
  // count one comparison, report a mismatch
  task cmp(input logic [15:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask
  // optional write, then a read of the same address
  task acc(input logic w, input logic [3:0] a, input logic [15:0] d, e);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    if (w) begin
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b1;
    end
    @(posedge clk);
    rd <= 1'b0;
    #1 cmp(rdata, e);
    @(posedge clk);
    #1 cmp(rdata, RD_RESET);
  endtask
  // new peripheral levels, then the pins two cycles later
  task pin_chk(input logic [31:0] f, input logic [15:0] e);
    @(posedge clk);
    func <= f;
    repeat (2) @(posedge clk);
    #1 cmp({10'h000, pins}, e);
  endtask
  // counts and verdict
  task wrap_up;
    $display("checks %0d fails %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 3; i++) acc(0, 4'(i), 16'h0000, 16'h0000);
    $display("reset test done");
    for (int i = 0; i < 3; i++) acc(1, 4'(i), 16'hFFFF, SEL_MASK);
    $display("absent bit test done");
    acc(1, 4'h0, 16'h0100, 16'h0100);
    acc(1, 4'h1, 16'h0302, 16'h0302);
    acc(1, 4'h2, 16'h1F04, 16'h1F04);
    pin_chk(32'h8000_000A, 16'h002A);
    pin_chk(32'h7FFF_FFF5, 16'h0015);
    $display("pin test done");
    acc(1, 4'h3, 16'hFFFF, 16'h0000);
    acc(1, 4'hF, 16'hFFFF, 16'h0000);
    acc(0, 4'h2, 16'h0000, 16'h1F04);
    $display("unmapped test done");
    wrap_up();
  end
endmodule
`default_nettype wire
